// *** verilog/ddr_timing_pkg.sv ***
// Timing constants, command codes and states for the DDR host controller
package ddr_timing_pkg;
  // ==========================================
  // Clock and geometry
  localparam int CLK_NS = 10;
  localparam int CK_DIV = 2;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int LANES = 2;
  localparam int LANE_W = 8;
  localparam int WORD_W = 2 * LANES * LANE_W;
  localparam int AP_BIT = 10;
  localparam int CNT_W = 16;
  // ==========================================
  // Times as given
  localparam int REFRESH_CYCLE_TIME_NS = 70;
  localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 15;
  localparam int PRECHARGE_PERIOD_NS = 15;
  localparam int BANK_TO_BANK_ACTIVATE_GAP_NS = 10;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int WRITE_TO_READ_GAP_CK = 2;
  localparam int ROW_OPEN_TIME_MIN_NS = 40;
  localparam int ROW_OPEN_TIME_MAX_NS = 70000;
  localparam int ROW_CYCLE_TIME_NS = 55;
  localparam int MODE_LOAD_WAIT_NS = 10;
  localparam int SELFREFRESH_EXIT_NONREAD_WAIT_NS = 70;
  localparam int SELFREFRESH_EXIT_READ_WAIT_CK = 200;
  localparam int AVERAGE_REFRESH_INTERVAL_NS = 7800;
  localparam int MAX_REFRESH_GAP_NS = 70300;
  localparam int MAX_POSTPONED_REFRESH = 8;
  // ==========================================
  // Cycle counts: minimums round up, maximums round down
  localparam int RFC_CYC = (REFRESH_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCD_CYC = (ACTIVATE_TO_ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (PRECHARGE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RRD_CYC = (BANK_TO_BANK_ACTIVATE_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = (WRITE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WTR_CYC = WRITE_TO_READ_GAP_CK * CK_DIV;
  localparam int RAS_CYC = (ROW_OPEN_TIME_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_CYC = (ROW_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_CYC = (MODE_LOAD_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int XSNR_CYC = (SELFREFRESH_EXIT_NONREAD_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int XSRD_CYC = SELFREFRESH_EXIT_READ_WAIT_CK * CK_DIV;
  localparam int REFI_CYC = AVERAGE_REFRESH_INTERVAL_NS / CLK_NS;
  // ==========================================
  // Write strobe steps and command codes {ras_n, cas_n, we_n}
  localparam int WSEQ_LAST = 5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  typedef enum {ST_IDLE, ST_ACT, ST_ACC, ST_PRE, ST_REF, ST_SREF, ST_SRX} state_type;
endpackage

// *** verilog/ddr_host_ctrl.sv ***
// Write data FIFO and DDR host controller with command timing
`timescale 1ns/10ps
// What this block does
// - Wait refresh cycle time after auto refresh
// - Honour activate-to-access and precharge periods
// - Space activates to different banks apart
// - Write recovery before precharge, gap before read
// - Write strobe lead and trail framing
// - Strobe valid by the write command cycle
// - Average refresh interval at most 7.8 us
// - Refreshes never more than 70.3 us apart
// - At most eight postponed or early refreshes
// - Self refresh exit wait before non-read
// - Self refresh exit 200 clocks before read
// - Auto precharge only when row time met
// - Clock enable high through refresh period
// - One strobe per eight-bit data lane
// - Row open between minimum and maximum time
// - Row cycle time between activates
// - Wait after mode load before commands

// ==========================================
// Write data FIFO
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  // Pointer and occupancy update
  always_comb begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  // Registered state and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      in_ready <= count_d != (AW + 1)'(DEPTH);
      out_valid <= count_d != '0;
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  assign out_data = mem_q[rd_ptr_q];
endmodule

// ==========================================
// DDR host controller
module ddr_host_ctrl
  import ddr_timing_pkg::*;
#(
  parameter int CAS_LATENCY_CK = 3,
  parameter int ROW_OPEN_MAX_CYC = ROW_OPEN_TIME_MAX_NS / CLK_NS,
  parameter int MAX_REFRESH_GAP_CYC = MAX_REFRESH_GAP_NS / CLK_NS,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Access requests
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [BANK_W-1:0] req_bank,
  input wire logic [ROW_W-1:0] req_row,
  input wire logic [COL_W-1:0] req_col,
  // Write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WORD_W-1:0] wr_data,
  // Read data
  output logic rd_valid,
  output logic [WORD_W-1:0] rd_data,
  output logic [LANES-1:0] rd_lane_ok,
  // Self refresh
  input wire logic sr_req,
  output logic sr_active,
  // Memory command pins
  output logic ddr_ck,
  output logic ddr_ck_n,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [BANK_W-1:0] ddr_ba,
  output logic [ROW_W-1:0] ddr_addr,
  // Memory data pins
  input wire logic [2*LANE_W-1:0] dq_in,
  output logic [2*LANE_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [LANES-1:0] dqs_in,
  output logic [LANES-1:0] dqs_out,
  output logic [LANES-1:0] dqs_oe
);
  localparam int RD_BEAT0 = 2 * CAS_LATENCY_CK + 4;
  localparam int RSEQ_LAST = RD_BEAT0 + 1;
  localparam int DW = 2 * LANE_W;

  logic [1:0] rst_sync_q;
  logic rst_s_n;
  logic [DW-1:0] dq_s1_q, dq_s2_q;
  logic [LANES-1:0] dqs_s1_q, dqs_s2_q;
  state_type st_q, st_d;
  logic [CNT_W-1:0] wait_q, wait_d, ras_q, ras_d, rc_q, rc_d, srx_q, srx_d, wtr_q, wtr_d;
  logic [CNT_W-1:0] tmr_q, tmr_d, gap_q, gap_d, open_q, open_d;
  logic [3:0] pend_q, pend_d;
  logic [4:0] wseq_q, wseq_d, rseq_q, rseq_d;
  logic ck_q, ck_d, cke_q, cke_d, ready_q, ready_d, have_q, have_d;
  logic [2:0] cmd_q, cmd_d;
  logic [BANK_W-1:0] ba_q, ba_d, rbank_q, rbank_d;
  logic [ROW_W-1:0] addr_q, addr_d, rrow_q, rrow_d;
  logic [COL_W-1:0] rcol_q, rcol_d;
  logic rwr_q, rwr_d, dq_oe_q, dq_oe_d, dqs_q, dqs_d, dqs_oe_q, dqs_oe_d;
  logic [WORD_W-1:0] wdat_q, wdat_d;
  logic [DW-1:0] dq_q, dq_d;
  logic rdv_q, rdv_d, take, slot, tick;
  logic iss_act, iss_rd, iss_wr, iss_pre, iss_ref;
  logic wq_valid, wq_pop;
  logic [WORD_W-1:0] wq_data;
  logic [CNT_W-1:0] since_act_q, since_pre_q, since_ref_q, since_srx_q;
  logic ck_n_q, sra_q, cs_n_q;

  // ==========================================
  // Reset release and pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_q[1];

  // Two stages before any logic reads the data pins
  always_ff @(posedge ref_clk) begin
    dq_s1_q <= dq_in;
    dq_s2_q <= dq_s1_q;
    dqs_s1_q <= dqs_in;
    dqs_s2_q <= dqs_s1_q;
  end

  // ==========================================
  // Write data queue
  data_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) wq (
    .clk(ref_clk),
    .rst_n(rst_s_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(wq_valid),
    .out_ready(wq_pop),
    .out_data(wq_data)
  );

  // ==========================================
  // Command sequencer
  always_comb begin
    st_d = st_q;
    wait_d = (wait_q != '0) ? wait_q - 1'b1 : '0;
    ras_d = (ras_q != '0) ? ras_q - 1'b1 : '0;
    rc_d = (rc_q != '0) ? rc_q - 1'b1 : '0;
    srx_d = (srx_q != '0) ? srx_q - 1'b1 : '0;
    wtr_d = (wtr_q != '0) ? wtr_q - 1'b1 : '0;
    ck_d = ~ck_q;
    cke_d = cke_q;
    cmd_d = ck_q ? CMD_NOP : cmd_q;
    ba_d = ba_q;
    addr_d = addr_q;
    have_d = have_q;
    rbank_d = rbank_q;
    rrow_d = rrow_q;
    rcol_d = rcol_q;
    rwr_d = rwr_q;
    wdat_d = wdat_q;
    wq_pop = 1'b0;
    iss_act = 1'b0;
    iss_rd = 1'b0;
    iss_wr = 1'b0;
    iss_pre = 1'b0;
    iss_ref = 1'b0;
    wseq_d = (wseq_q != 5'h00 && wseq_q != 5'(WSEQ_LAST)) ? wseq_q + 5'h01 : 5'h00;
    rseq_d = (rseq_q != 5'h00 && rseq_q != 5'(RSEQ_LAST)) ? rseq_q + 5'h01 : 5'h00;
    take = req_valid & ready_q & (~req_write | wq_valid);
    slot = ck_q & (wait_q == '0);
    // Latch one request
    if (take) begin
      have_d = 1'b1;
      rbank_d = req_bank;
      rrow_d = req_row;
      rcol_d = req_col;
      rwr_d = req_write;
    end
    if (slot) begin
      case (st_q)
        ST_IDLE: begin
          if (rc_q == '0 && pend_q != 4'h0 && (pend_q == 4'(MAX_POSTPONED_REFRESH) || !have_q)) begin
            cmd_d = CMD_REF;
            iss_ref = 1'b1;
            wait_d = CNT_W'(RFC_CYC);
            rc_d = CNT_W'(RFC_CYC);
            st_d = ST_REF;
          end else if (have_q && rc_q == '0) begin
            cmd_d = CMD_ACT;
            iss_act = 1'b1;
            ba_d = rbank_q;
            addr_d = rrow_q;
            wait_d = CNT_W'(RCD_CYC);
            ras_d = CNT_W'(RAS_CYC);
            rc_d = CNT_W'((RC_CYC > RRD_CYC) ? RC_CYC : RRD_CYC);
            st_d = ST_ACT;
          end else if (sr_req && !have_q && pend_q == 4'h0 && rc_q == '0) begin
            cmd_d = CMD_REF;
            iss_ref = 1'b1;
            cke_d = 1'b0;
            st_d = ST_SREF;
          end
        end
        ST_ACT: begin
          if (rwr_q && wseq_q == 5'h00 && rseq_q == 5'h00) begin
            cmd_d = CMD_WR;
            iss_wr = 1'b1;
            have_d = 1'b0;
            wq_pop = 1'b1;
            wdat_d = wq_data;
            addr_d = ROW_W'(rcol_q);
            addr_d[AP_BIT] = 1'b0;
            wseq_d = 5'h01;
            wait_d = CNT_W'(WSEQ_LAST + WR_CYC);
            wtr_d = CNT_W'(WSEQ_LAST + WTR_CYC);
            st_d = ST_ACC;
          end else if (!rwr_q && srx_q == '0 && wtr_q == '0 && rseq_q == 5'h00 && wseq_q == 5'h00) begin
            cmd_d = CMD_RD;
            iss_rd = 1'b1;
            have_d = 1'b0;
            addr_d = ROW_W'(rcol_q);
            addr_d[AP_BIT] = 1'b0;
            rseq_d = 5'h01;
            st_d = ST_ACC;
          end
        end
        ST_ACC: begin
          if (ras_q == '0) begin
            cmd_d = CMD_PRE;
            iss_pre = 1'b1;
            addr_d[AP_BIT] = 1'b0;
            wait_d = CNT_W'(RP_CYC);
            st_d = ST_PRE;
          end
        end
        ST_PRE: st_d = ST_IDLE;
        ST_REF: st_d = ST_IDLE;
        ST_SREF: begin
          if (!sr_req) begin
            cke_d = 1'b1;
            wait_d = CNT_W'(XSNR_CYC);
            srx_d = CNT_W'(XSRD_CYC);
            st_d = ST_SRX;
          end
        end
        ST_SRX: st_d = ST_IDLE;
        default: st_d = ST_IDLE;
      endcase
    end
    ready_d = ~have_d & ~sr_req;
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_q <= ST_IDLE;
      wait_q <= CNT_W'(MRD_CYC);
      ras_q <= '0;
      rc_q <= '0;
      srx_q <= '0;
      wtr_q <= '0;
      ck_q <= 1'b0;
      ck_n_q <= 1'b1;
      sra_q <= 1'b0;
      cs_n_q <= 1'b1;
      cke_q <= 1'b1;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      have_q <= 1'b0;
      ready_q <= 1'b0;
      rbank_q <= '0;
      rrow_q <= '0;
      rcol_q <= '0;
      rwr_q <= 1'b0;
      wdat_q <= '0;
      wseq_q <= 5'h00;
      rseq_q <= 5'h00;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      ras_q <= ras_d;
      rc_q <= rc_d;
      srx_q <= srx_d;
      wtr_q <= wtr_d;
      ck_q <= ck_d;
      ck_n_q <= ck_q;
      sra_q <= ~cke_d;
      cs_n_q <= 1'b0;
      cke_q <= cke_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
      have_q <= have_d;
      ready_q <= ready_d;
      rbank_q <= rbank_d;
      rrow_q <= rrow_d;
      rcol_q <= rcol_d;
      rwr_q <= rwr_d;
      wdat_q <= wdat_d;
      wseq_q <= wseq_d;
      rseq_q <= rseq_d;
    end
  end

  // ==========================================
  // Refresh scheduling
  always_comb begin
    tick = tmr_q == CNT_W'(REFI_CYC - 1);
    tmr_d = tick ? '0 : tmr_q + 1'b1;
    pend_d = pend_q + 4'(tick) - 4'(iss_ref & cke_d);
    gap_d = iss_ref ? '0 : gap_q + 1'b1;
    open_d = iss_act ? 16'h0001 : (st_q == ST_ACT || st_q == ST_ACC) ? open_q + 1'b1 : '0;
    if (st_q == ST_SREF) begin
      tmr_d = '0;
      pend_d = 4'h0;
      gap_d = '0;
    end
  end

  // Refresh registers
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      tmr_q <= '0;
      pend_q <= 4'h0;
      gap_q <= '0;
      open_q <= '0;
    end else begin
      tmr_q <= tmr_d;
      pend_q <= pend_d;
      gap_q <= gap_d;
      open_q <= open_d;
    end
  end

  // ==========================================
  // Write strobe framing and read capture control
  always_comb begin
    dqs_oe_d = wseq_d >= 5'h01 && wseq_d <= 5'h04;
    dqs_d = wseq_d == 5'h03;
    dq_oe_d = wseq_d == 5'h02 || wseq_d == 5'h03;
    dq_d = (wseq_d == 5'h03) ? wdat_d[WORD_W-1:DW] : wdat_d[DW-1:0];
    rdv_d = rseq_q == 5'(RSEQ_LAST);
  end

  // Data path registers
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      dqs_oe_q <= 1'b0;
      dqs_q <= 1'b0;
      dq_oe_q <= 1'b0;
      dq_q <= '0;
      rdv_q <= 1'b0;
    end else begin
      dqs_oe_q <= dqs_oe_d;
      dqs_q <= dqs_d;
      dq_oe_q <= dq_oe_d;
      dq_q <= dq_d;
      rdv_q <= rdv_d;
    end
  end

  // Per-lane strobe drive and read capture
  for (genvar g = 0; g < LANES; g++) begin : lane
    logic [LANE_W-1:0] b0_q, b0_d, b1_q, b1_d;
    logic ok_q, ok_d;
    always_comb begin
      b0_d = (rseq_q == 5'(RD_BEAT0)) ? dq_s2_q[g*LANE_W +: LANE_W] : b0_q;
      b1_d = (rseq_q == 5'(RD_BEAT0 + 1)) ? dq_s2_q[g*LANE_W +: LANE_W] : b1_q;
      ok_d = (rseq_q == 5'(RD_BEAT0)) ? dqs_s2_q[g] : ok_q;
    end
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
        b0_q <= '0;
        b1_q <= '0;
        ok_q <= 1'b0;
      end else begin
        b0_q <= b0_d;
        b1_q <= b1_d;
        ok_q <= ok_d;
      end
    end
    assign rd_data[g*LANE_W +: LANE_W] = b0_q;
    assign rd_data[DW + g*LANE_W +: LANE_W] = b1_q;
    assign rd_lane_ok[g] = ok_q;
    assign dqs_out[g] = dqs_q;
    assign dqs_oe[g] = dqs_oe_q;
  end

  // ==========================================
  // Outputs from registers
  assign req_ready = ready_q;
  assign rd_valid = rdv_q;
  assign sr_active = sra_q;
  assign ddr_ck = ck_q;
  assign ddr_ck_n = ck_n_q;
  assign ddr_cke = cke_q;
  assign ddr_cs_n = cs_n_q;
  assign {ddr_ras_n, ddr_cas_n, ddr_we_n} = cmd_q;
  assign ddr_ba = ba_q;
  assign ddr_addr = addr_q;
  assign dq_out = dq_q;
  assign dq_oe = dq_oe_q;

  // ==========================================
  // Helper counters since activate, precharge, refresh and self refresh exit
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      since_act_q <= '1;
      since_pre_q <= '1;
      since_ref_q <= '1;
      since_srx_q <= '1;
    end else begin
      since_act_q <= iss_act ? 16'h0001 : (&since_act_q ? since_act_q : since_act_q + 1'b1);
      since_pre_q <= iss_pre ? 16'h0001 : (&since_pre_q ? since_pre_q : since_pre_q + 1'b1);
      since_ref_q <= iss_ref ? 16'h0001 : (&since_ref_q ? since_ref_q : since_ref_q + 1'b1);
      since_srx_q <= !cke_q ? 16'h0001 : (&since_srx_q ? since_srx_q : since_srx_q + 1'b1);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_s_n);

  refresh_period_a: assert property ((iss_act | iss_ref) |-> since_ref_q >= 16'(RFC_CYC))
    else $error("command inside refresh period");
  access_delay_a: assert property ((iss_rd | iss_wr) |-> since_act_q >= 16'(RCD_CYC))
    else $error("access too soon after activate");
  precharge_gap_a: assert property (iss_act |-> since_pre_q >= 16'(RP_CYC))
    else $error("activate too soon after precharge");
  row_cycle_a: assert property (iss_act |-> since_act_q >= 16'(RC_CYC))
    else $error("activates too close");
  row_open_a: assert property (iss_pre |-> since_act_q >= 16'(RAS_CYC) && open_q < 16'(ROW_OPEN_MAX_CYC))
    else $error("row open time out of range");
  refresh_gap_a: assert property (gap_q < 16'(MAX_REFRESH_GAP_CYC))
    else $error("refresh gap too long");
  postpone_limit_a: assert property (pend_q <= 4'(MAX_POSTPONED_REFRESH))
    else $error("too many postponed refreshes");
  refresh_cke_a: assert property ((st_q == ST_REF) |-> ddr_cke)
    else $error("clock enable low during refresh");
  write_strobe_a: assert property (iss_wr |=> (dqs_oe[0] && !dqs_out[0])[*2] ##1
    (dqs_out[0] && dq_oe) ##1 (dqs_oe[0] && !dqs_out[0]) ##1 !dqs_oe[0])
    else $error("write strobe framing wrong");
  sr_read_a: assert property (iss_rd |-> since_srx_q >= 16'(XSRD_CYC))
    else $error("read too soon after self refresh");
endmodule

// *** bench/ddr_device_model.sv ***
// Behavioural DDR device model that stores data and polices command timing
`timescale 1ns/10ps
module ddr_device_model
  import ddr_timing_pkg::*;
#(
  parameter int CAS_CK = 3
) (
  // Clock and command
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0] addr,
  // Data
  input wire logic [2*LANE_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [LANES-1:0] dqs_out,
  input wire logic [LANES-1:0] dqs_oe,
  output logic [2*LANE_W-1:0] dq_in = 16'hA5C3,
  output logic [LANES-1:0] dqs_in = 2'h1
);
  localparam real CK_NS = CLK_NS * CK_DIV;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wkey, key, wword;
  logic [2:0] cmd;
  logic [ROW_W-1:0] row_q [4];
  realtime act_t [4] = '{4{-1e6}};
  realtime pre_t [4] = '{4{-1e6}};
  realtime now, any_act = -1e6, ref_t = -1e6, gap_t = 0, srx_t = -1e6, wend_t = -1e6;
  realtime oe_t = -1e6, fall_t = -1e6;
  int violations = 0;
  int refreshes = 0;
  bit sr = 0, wr_on = 0, rbusy = 0;

  function automatic void flag(bit bad);
    if (bad) violations++;
  endfunction

  // Released lines never hold the last beat
  always @(ck) if (!rbusy) begin
    dq_in = ~dq_in;
    dqs_in = ~dqs_in;
  end

  // Read burst: preamble, then two beats framed by each lane's strobe
  task automatic send(logic [31:0] w);
    repeat (CAS_CK - 1) @(posedge ck);
    rbusy = 1;
    dqs_in = '0;
    @(posedge ck);
    dq_in = w[15:0];
    dqs_in = '1;
    @(negedge ck);
    dq_in = w[31:16];
    dqs_in = '0;
    @(posedge ck);
    rbusy = 0;
  endtask

  // Command decode and spacing checks at each memory clock rise
  always @(posedge ck) begin
    cmd = {ras_n, cas_n, we_n};
    now = $realtime;
    if (sr && cke) begin
      sr = 0;
      srx_t = now;
      gap_t = now;
    end
    if (now - ref_t < REFRESH_CYCLE_TIME_NS) flag(!cke);
    if (!cs_n && cmd != CMD_NOP) begin
      flag(cmd != CMD_RD && now - srx_t < SELFREFRESH_EXIT_NONREAD_WAIT_NS);
      key = {7'h00, ba, row_q[ba], addr[COL_W-1:0]};
      case (cmd)
        CMD_ACT: begin
          flag(now - ref_t < REFRESH_CYCLE_TIME_NS);
          flag(now - pre_t[ba] < PRECHARGE_PERIOD_NS);
          flag(now - any_act < BANK_TO_BANK_ACTIVATE_GAP_NS);
          flag(now - act_t[ba] < ROW_CYCLE_TIME_NS);
          act_t[ba] = now;
          any_act = now;
          row_q[ba] = addr;
        end
        CMD_RD, CMD_WR: begin
          flag(now - act_t[ba] < ACTIVATE_TO_ACCESS_DELAY_NS);
          flag(addr[AP_BIT] && now - act_t[ba] + CK_NS < ROW_OPEN_TIME_MIN_NS);
          if (cmd == CMD_RD) begin
            flag(now - wend_t < WRITE_TO_READ_GAP_CK * CK_NS);
            flag(now - srx_t < SELFREFRESH_EXIT_READ_WAIT_CK * CK_NS);
            fork
              send(mem.exists(key) ? mem[key] : ~key);
            join_none
          end else begin
            flag(dqs_oe !== '1);
            wkey = key;
            wr_on = 1;
          end
        end
        CMD_PRE: begin
          flag(now - wend_t < WRITE_RECOVERY_NS);
          flag(now - act_t[ba] < ROW_OPEN_TIME_MIN_NS);
          flag(now - act_t[ba] > ROW_OPEN_TIME_MAX_NS);
          pre_t[ba] = now;
        end
        CMD_REF: begin
          flag(now - ref_t < REFRESH_CYCLE_TIME_NS);
          flag(now - any_act < ROW_CYCLE_TIME_NS);
          flag(refreshes > 0 && now - gap_t > MAX_REFRESH_GAP_NS);
          flag(refreshes - int'(now / AVERAGE_REFRESH_INTERVAL_NS) > MAX_POSTPONED_REFRESH);
          flag(int'(now / AVERAGE_REFRESH_INTERVAL_NS) - refreshes > MAX_POSTPONED_REFRESH + 1);
          if (!cke) sr = 1;
          else ref_t = now;
          gap_t = now;
          refreshes++;
        end
        default: ;
      endcase
    end
  end

  // Each lane takes its byte by its own strobe level, however late it starts
  always @(ck) begin
    #1;
    if (wr_on && dq_oe) for (int l = 0; l < LANES; l++) begin
      if (dqs_out[l]) wword[16+l*8 +: 8] = dq_out[l*8 +: 8];
      else wword[l*8 +: 8] = dq_out[l*8 +: 8];
    end
  end

  // End of write data: store word, start recovery timing
  always @(negedge dq_oe) if (wr_on) begin
    mem[wkey] = wword;
    wend_t = $realtime;
    wr_on = 0;
  end

  // Strobe preamble and postamble widths
  always @(posedge dqs_oe[0]) oe_t = $realtime;
  always @(negedge dqs_out[0]) fall_t = $realtime;
  always @(posedge dqs_out[0]) if (dqs_oe[0]) flag($realtime - oe_t < 0.25 * CK_NS);
  always @(negedge dqs_oe[0]) if ($realtime - oe_t < 4 * CK_NS) begin
    flag($realtime - fall_t < 0.4 * CK_NS || $realtime - fall_t > 0.6 * CK_NS);
  end
endmodule

// *** bench/ddr_command_timing_rules_tb.sv ***
// Self-checking bench for the DDR host controller against the device model
`timescale 1ns/10ps
module ddr_command_timing_rules_tb;
  import ddr_timing_pkg::*;
  // ==========================================
  // Signals
  logic ref_clk = 0, rst_n = 0, req_valid = 0, req_write = 0, wr_valid = 0, sr_req = 0;
  logic [BANK_W-1:0] req_bank = '0, ddr_ba;
  logic [ROW_W-1:0] req_row = '0, ddr_addr;
  logic [COL_W-1:0] req_col = '0;
  logic [WORD_W-1:0] wr_data = '0, rd_data;
  logic req_ready, wr_ready, rd_valid, sr_active, ddr_ck, ddr_ck_n, ddr_cke, ddr_cs_n;
  logic ddr_ras_n, ddr_cas_n, ddr_we_n, dq_oe;
  logic [LANES-1:0] rd_lane_ok, dqs_in, dqs_out, dqs_oe;
  logic [2*LANE_W-1:0] dq_in, dq_out;
  logic [31:0] shadow [logic [31:0]];
  logic [31:0] pool [8], fk [16], fw [16];
  int mismatches = 0, checks_done = 0, refs0, n;

  // Clock
  always #(CLK_NS / 2) ref_clk = ~ref_clk;

  ddr_host_ctrl #(.CAS_LATENCY_CK(3)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank),
    .req_row(req_row), .req_col(req_col), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .rd_lane_ok(rd_lane_ok),
    .sr_req(sr_req), .sr_active(sr_active), .ddr_ck(ddr_ck), .ddr_ck_n(ddr_ck_n),
    .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
    .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

  ddr_device_model #(.CAS_CK(3)) mem_u (.ck(ddr_ck), .cke(ddr_cke), .cs_n(ddr_cs_n),
    .ras_n(ddr_ras_n), .cas_n(ddr_cas_n), .we_n(ddr_we_n), .ba(ddr_ba), .addr(ddr_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dq_in(dq_in),
    .dqs_in(dqs_in));

  // ==========================================
  // Compare, verdict
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Expected read word: last write, else the device's untouched pattern
  function automatic logic [31:0] expect_word(logic [31:0] k);
    return shadow.exists(k) ? shadow[k] : ~k;
  endfunction

  // ==========================================
  // Bus tasks
  task automatic push(logic [31:0] w);
    @(negedge ref_clk);
    wr_valid = 1;
    wr_data = w;
    n = 0;
    while (wr_ready !== 1'b1 && n < 3000) begin @(negedge ref_clk); n++; end
    check("wr ready", 32'(wr_ready), 32'h1);
    @(negedge ref_clk);
    wr_valid = 0;
  endtask

  task automatic access(bit wr, logic [31:0] k, logic [31:0] w, bit pushed);
    if (wr && !pushed) push(w);
    if (wr) shadow[k] = w;
    @(negedge ref_clk);
    req_valid = 1;
    req_write = wr;
    {req_bank, req_row, req_col} = k[24:0];
    n = 0;
    while (req_ready !== 1'b1 && n < 3000) begin @(negedge ref_clk); n++; end
    check("req ready", 32'(req_ready), 32'h1);
    @(negedge ref_clk);
    req_valid = 0;
    if (!wr) begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 600) begin @(negedge ref_clk); n++; end
      check("read valid", 32'(rd_valid), 32'h1);
      check("read word", rd_data, expect_word(k));
      check("lane strobes", 32'(rd_lane_ok), 32'h3);
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(64194));
    repeat (16) @(negedge ref_clk);
    check("cke in reset", 32'(ddr_cke), 32'h1);
    check("select in reset", 32'(ddr_cs_n), 32'h1);
    rst_n = 1;
    repeat (4) @(negedge ref_clk);
    check("ready after reset", 32'(req_ready), 32'h1);
    check("ck pair", 32'(ddr_ck ^ ddr_ck_n), 32'h1);
    foreach (pool[i]) pool[i] = {7'h00, 25'($urandom)};
    // Fill the write buffer until it refuses, then drain it by writes
    wr_valid = 1;
    for (int i = 0; i < 16; i++) begin
      fw[i] = $urandom;
      wr_data = fw[i];
      @(negedge ref_clk);
    end
    wr_valid = 0;
    @(negedge ref_clk);
    check("full buffer", 32'(wr_ready), 32'h0);
    wr_valid = 1;
    wr_data = 32'hFFFFFFFF;
    repeat (2) @(negedge ref_clk);
    check("full buffer held", 32'(wr_ready), 32'h0);
    wr_valid = 0;
    for (int i = 0; i < 16; i++) begin
      fk[i] = {7'h00, 25'($urandom)};
      access(1, fk[i], fw[i], 1);
    end
    check("buffer drained", 32'(wr_ready), 32'h1);
    for (int i = 15; i >= 0; i--) access(0, fk[i], '0, 0);
    // Random mix over a small pool so rows and banks collide
    repeat (60) access(1'($urandom), pool[$urandom % 8], $urandom, 0);
    // Idle: refreshes keep their pace
    refs0 = mem_u.refreshes;
    repeat (2300) @(negedge ref_clk);
    n = mem_u.refreshes - refs0;
    check("idle refreshes", 32'(n >= 2 && n <= 11), 32'h1);
    // Self refresh, then a read at once
    sr_req = 1;
    n = 0;
    while (sr_active !== 1'b1 && n < 3000) begin @(negedge ref_clk); n++; end
    check("self refresh flag", 32'(sr_active), 32'h1);
    repeat (300) @(negedge ref_clk);
    check("self refresh cke", 32'(ddr_cke), 32'h0);
    check("refused in self refresh", 32'(req_ready), 32'h0);
    sr_req = 0;
    access(0, pool[0], '0, 0);
    access(1, pool[1], $urandom, 0);
    access(0, pool[1], '0, 0);
    check("device timing faults", 32'(mem_u.violations), 32'h0);
    conclude();
  end

  // Watchdog
  initial begin
    #1_000_000;
    mismatches++;
    conclude();
  end
endmodule
